// file: logic/audio_if_clock_generator.sv
/*
 * Audio interface clock generator: bit clock and frame clock in master mode,
 * pin direction control, and the auxiliary clock for a general purpose pin.
 * Assumes one system clock, a simple register port, and an outside wire that
 * resolves the two-way pins from the output enables.
 */
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module audio_if_clock_generator
   import aif_clk_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // register port
   input wire logic [7:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   // bit clock pin
   input wire logic bit_clock_i,
   output logic bit_clock_o,
   output logic bit_clock_oe,
   // frame clock pin
   input wire logic frame_clock_i,
   output logic frame_clock_o,
   output logic frame_clock_oe,
   // general purpose clock pin
   output logic gpio_output_clock
);

   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic [3:0] gpio_clock_divider_select_q, gpio_clock_divider_select_d;
   logic [4:0] bclk_sel_q, bclk_sel_d;
   logic frame_dir_q, frame_dir_d;
   logic [10:0] frame_rate_q, frame_rate_d;
   logic bclk_dir_q, bclk_dir_d;
   logic [15:0] rdata_q, rdata_d;
   logic [15:0] status;

   always_comb begin
      gpio_clock_divider_select_d = gpio_clock_divider_select_q;
      bclk_sel_d = bclk_sel_q;
      frame_dir_d = frame_dir_q;
      frame_rate_d = frame_rate_q;
      bclk_dir_d = bclk_dir_q;
      rdata_d = '0;
      if (wr) begin
         unique case (addr)
            ADDR_LINK_CTRL: begin
               bclk_dir_d = wdata[BCLK_DIR_BIT];
            end
            ADDR_DIVIDERS: begin
               gpio_clock_divider_select_d = wdata[GPIO_SEL_LSB +: GPIO_SEL_W];
               bclk_sel_d = wdata[BCLK_SEL_LSB +: BCLK_SEL_W];
            end
            ADDR_FRAME_CTRL: begin
               frame_dir_d = wdata[FRAME_DIR_BIT];
               frame_rate_d = wdata[RATE_LSB +: RATE_W];
            end
            default: begin
            end
         endcase
      end
      if (rd) begin
         unique case (addr)
            ADDR_LINK_CTRL: begin
               rdata_d[BCLK_DIR_BIT] = bclk_dir_q;
            end
            ADDR_DIVIDERS: begin
               rdata_d[GPIO_SEL_LSB +: GPIO_SEL_W] = gpio_clock_divider_select_q;
               rdata_d[BCLK_SEL_LSB +: BCLK_SEL_W] = bclk_sel_q;
            end
            ADDR_FRAME_CTRL: begin
               rdata_d[FRAME_DIR_BIT] = frame_dir_q;
               rdata_d[RATE_LSB +: RATE_W] = frame_rate_q;
            end
            ADDR_STATUS: begin
               rdata_d = status;
            end
            default: begin
               rdata_d = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         gpio_clock_divider_select_q <= GPIO_SEL_RST;
         bclk_sel_q <= BCLK_SEL_RST;
         frame_dir_q <= FRAME_DIR_RST;
         frame_rate_q <= FRAME_RATE_RST;
         bclk_dir_q <= BCLK_DIR_RST;
         rdata_q <= '0;
      end else begin
         gpio_clock_divider_select_q <= gpio_clock_divider_select_d;
         bclk_sel_q <= bclk_sel_d;
         frame_dir_q <= frame_dir_d;
         frame_rate_q <= frame_rate_d;
         bclk_dir_q <= bclk_dir_d;
         rdata_q <= rdata_d;
      end
   end

   assign rdata = rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // dividers from the system clock
   logic bclk_int, bclk_rise, gpio_clk_int;
   half_t bclk_half, gpio_half;

   always_comb begin
      bclk_half = bclk_half_units(bclk_sel_q);
      // reserved gpio codes fall back to divide by one, reserved bclk codes to divide by four
      gpio_half = gpio_half_units(gpio_clock_divider_select_q);
   end

   half_step_divider u_bclk_div (
      .clk(clk),
      .rst_b(rst_b),
      .half_units(bclk_half),
      .clk_o(bclk_int),
      .rise(bclk_rise)
   );

   half_step_divider u_gpio_div (
      .clk(clk),
      .rst_b(rst_b),
      .half_units(gpio_half),
      .clk_o(gpio_clk_int),
      .rise()
   );

   assign gpio_output_clock = gpio_clk_int;

   ////////////////////////////////////////////////////////////////////////////
   // frame clock: counts bit clock periods, rate taken at frame boundary
   logic [10:0] frame_cnt_q, frame_cnt_d, rate_act_q, rate_act_d;
   logic frame_lvl_q, frame_lvl_d;
   logic [11:0] cnt_plus;

   always_comb begin
      frame_cnt_d = frame_cnt_q;
      rate_act_d = rate_act_q;
      cnt_plus = {1'b0, frame_cnt_q} + 12'h001;
      if (bclk_rise) begin
         // values below the supported minimum still wrap safely
         if (cnt_plus >= {1'b0, rate_act_q}) begin
            frame_cnt_d = '0;
            rate_act_d = frame_rate_q;
         end else begin
            frame_cnt_d = cnt_plus[10:0];
         end
      end
      frame_lvl_d = (frame_cnt_d < (rate_act_d >> 1));
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         frame_cnt_q <= '0;
         rate_act_q <= FRAME_RATE_RST;
         frame_lvl_q <= 1'b0;
      end else begin
         frame_cnt_q <= frame_cnt_d;
         rate_act_q <= rate_act_d;
         frame_lvl_q <= frame_lvl_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin drive
   assign bit_clock_oe = bclk_dir_q;
   assign bit_clock_o = bclk_dir_q & bclk_int;
   assign frame_clock_oe = frame_dir_q;
   assign frame_clock_o = frame_dir_q & frame_lvl_q;

   ////////////////////////////////////////////////////////////////////////////
   // pin input synchronisers, level taken once stages two and three agree
   logic [2:0] fsync_q, fsync_d, bsync_q, bsync_d;
   logic fpin_q, fpin_d, bpin_q, bpin_d;

   always_comb begin
      fsync_d = {fsync_q[1:0], frame_clock_i};
      bsync_d = {bsync_q[1:0], bit_clock_i};
      fpin_d = (fsync_q[1] == fsync_q[2]) ? fsync_q[2] : fpin_q;
      bpin_d = (bsync_q[1] == bsync_q[2]) ? bsync_q[2] : bpin_q;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         fsync_q <= '0;
         bsync_q <= '0;
         fpin_q <= 1'b0;
         bpin_q <= 1'b0;
      end else begin
         fsync_q <= fsync_d;
         bsync_q <= bsync_d;
         fpin_q <= fpin_d;
         bpin_q <= bpin_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status word
   always_comb begin
      status = '0;
      status[ST_FRAME_PIN_BIT] = fpin_q;
      status[ST_BCLK_PIN_BIT] = bpin_q;
      status[ST_BCLK_BIT] = bclk_int;
      status[ST_FRAME_BIT] = frame_lvl_q;
   end

endmodule // audio_if_clock_generator

// file: logic/half_step_divider.sv
/*
 * Clock divider with half system clock resolution, so ratios such as 1.5
 * and 5.5 come out with exact mean frequency.
 * Assumes the ratio input is at least two half periods.
 */
`timescale 1ns/1ps
module half_step_divider
   import aif_clk_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // ratio in half periods of clk
   input wire half_t half_units,
   // divided clock and a pulse in the cycle of its rising edge
   output logic clk_o,
   output logic rise
);

   half_t phase_q, phase_d, ratio_q, ratio_d, p1, p2;
   logic first_d, second_q, second_d, pos_q, pos_d, neg_q, neg_d;
   logic rise_q, rise_d;
   logic [HALF_W:0] sum1, sum2;

   ////////////////////////////////////////////////////////////////////////////
   // phase walks two half periods per clock; ratio is taken only at wrap
   always_comb begin
      sum1 = {1'b0, phase_q} + 8'h01;
      sum2 = {1'b0, phase_q} + 8'h02;
      p1 = (sum1 >= {1'b0, ratio_q}) ? half_t'(sum1 - {1'b0, ratio_q}) : half_t'(sum1);
      p2 = (sum2 >= {1'b0, ratio_q}) ? half_t'(sum2 - {1'b0, ratio_q}) : half_t'(sum2);
      phase_d = p2;
      ratio_d = ratio_q;
      // new ratio only at a period boundary, so no runt
      if (sum2 >= {1'b0, ratio_q}) begin
         ratio_d = half_units;
         if (p2 >= half_units) begin
            phase_d = '0;
         end
      end
      // high for the first half of each period, odd half counts included
      first_d = ({1'b0, phase_q} < ({1'b0, ratio_q} + 8'h01) >> 1);
      second_d = ({1'b0, p1} < ({1'b0, ratio_q} + 8'h01) >> 1);
      rise_d = (phase_q == '0) || (p1 == '0);
      // first half level taken straight from this phase, so both halves of one
      // phase step show in order and odd ratios keep their period
      pos_d = first_d ^ neg_q;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         phase_q <= '0;
         ratio_q <= HALF_RST;
         second_q <= 1'b0;
         pos_q <= 1'b0;
         rise_q <= 1'b0;
      end else begin
         phase_q <= phase_d;
         ratio_q <= ratio_d;
         second_q <= second_d;
         pos_q <= pos_d;
         rise_q <= rise_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // second half level lands on the falling edge; xor of two flops is glitch free
   always_comb begin
      neg_d = second_q ^ pos_q;
   end

   always_ff @(negedge clk) begin
      if (!rst_b) begin
         neg_q <= 1'b0;
      end else begin
         neg_q <= neg_d;
      end
   end

   assign clk_o = pos_q ^ neg_q;
   assign rise = rise_q;

endmodule // half_step_divider

// file: pkg/aif_clk_pkg.sv
/*
 * Shared constants for the audio interface clock generator: register offsets,
 * field positions, reset values and the divider ratio decode tables.
 * Assumes a register port with 8-bit word addresses and 16-bit data.
 */
package aif_clk_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register offsets
   localparam logic [7:0] ADDR_LINK_CTRL = 8'h19;
   localparam logic [7:0] ADDR_DIVIDERS = 8'h1a;
   localparam logic [7:0] ADDR_FRAME_CTRL = 8'h1b;
   localparam logic [7:0] ADDR_STATUS = 8'h1c;

   ////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int GPIO_SEL_LSB = 8;
   localparam int GPIO_SEL_W = 4;
   localparam int BCLK_SEL_LSB = 0;
   localparam int BCLK_SEL_W = 5;
   localparam int FRAME_DIR_BIT = 11;
   localparam int RATE_LSB = 0;
   localparam int RATE_W = 11;
   localparam int BCLK_DIR_BIT = 6;
   localparam int ST_FRAME_PIN_BIT = 0;
   localparam int ST_BCLK_PIN_BIT = 1;
   localparam int ST_BCLK_BIT = 2;
   localparam int ST_FRAME_BIT = 3;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [4:0] BCLK_SEL_RST = 5'h04;
   localparam logic [3:0] GPIO_SEL_RST = 4'h0;
   localparam logic [10:0] FRAME_RATE_RST = 11'h040;
   localparam logic FRAME_DIR_RST = 1'b0;
   localparam logic BCLK_DIR_RST = 1'b0;

   // a divider ratio is held in half system clock periods
   localparam int HALF_W = 7;
   typedef logic [HALF_W-1:0] half_t;
   localparam half_t HALF_RST = 7'h08;

   ////////////////////////////////////////////////////////////////////////////
   // ratio decode, result in half periods of the system clock
   function automatic half_t bclk_half_units(input logic [4:0] sel);
      unique case (sel)
         5'h00: bclk_half_units = 7'h02;
         5'h01: bclk_half_units = 7'h03;
         5'h02: bclk_half_units = 7'h04;
         5'h03: bclk_half_units = 7'h06;
         5'h04: bclk_half_units = 7'h08;
         5'h05: bclk_half_units = 7'h0a;
         5'h06: bclk_half_units = 7'h0b;
         5'h07: bclk_half_units = 7'h0c;
         5'h08: bclk_half_units = 7'h10;
         5'h09: bclk_half_units = 7'h14;
         5'h0a: bclk_half_units = 7'h16;
         5'h0b: bclk_half_units = 7'h18;
         5'h0c: bclk_half_units = 7'h20;
         5'h0d: bclk_half_units = 7'h28;
         5'h0e: bclk_half_units = 7'h2c;
         5'h0f: bclk_half_units = 7'h30;
         5'h10: bclk_half_units = 7'h32;
         5'h11: bclk_half_units = 7'h3c;
         5'h12: bclk_half_units = 7'h40;
         5'h13: bclk_half_units = 7'h58;
         5'h14: bclk_half_units = 7'h60;
         default: bclk_half_units = HALF_RST;
      endcase
   endfunction

   function automatic half_t gpio_half_units(input logic [3:0] sel);
      unique case (sel)
         4'h0: gpio_half_units = 7'h02;
         4'h1: gpio_half_units = 7'h04;
         4'h2: gpio_half_units = 7'h06;
         4'h3: gpio_half_units = 7'h08;
         4'h4: gpio_half_units = 7'h0b;
         4'h5: gpio_half_units = 7'h0c;
         4'h6: gpio_half_units = 7'h10;
         4'h7: gpio_half_units = 7'h18;
         4'h8: gpio_half_units = 7'h20;
         default: gpio_half_units = 7'h02;
      endcase
   endfunction

endpackage

// file: verif/aif_host_model.sv
/*
 * Host side of the audio link: drives both clock pins while the block
 * leaves them as inputs, and resolves each two-way pin to one level.
 * Assumes the block raises an output enable while it drives that pin.
 */
`timescale 1ns/1ps
module aif_host_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // block side of the pins
   input wire logic bit_o,
   input wire logic bit_oe,
   input wire logic frame_o,
   input wire logic frame_oe,
   // resolved pin levels
   output logic bit_pin,
   output logic frame_pin
);
   logic [7:0] cnt_q = 8'h00;

   always @(posedge clk) cnt_q <= rst_b ? cnt_q + 8'h01 : 8'h00;

   // host clocks reach the pins only while the block listens
   assign bit_pin = bit_oe ? bit_o : cnt_q[2];
   assign frame_pin = frame_oe ? frame_o : cnt_q[7];
endmodule // aif_host_model

// file: verif/audio_if_clock_generator_sva.sv
/*
 * Checker for the clock generator ports.
 * Assumes it is bound into audio_if_clock_generator.
 */
`timescale 1ns/1ps
module aif_clk_sva
   import aif_clk_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // register port
   input wire logic [7:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [15:0] rdata,
   // pins
   input wire logic bit_clock_o,
   input wire logic bit_clock_oe,
   input wire logic frame_clock_o,
   input wire logic frame_clock_oe
);
   // length of the current bit clock level while driven
   logic [5:0] run_q;
   logic [5:0] run_d;
   logic last_q;
   logic mid_q;

   // a cycle extends the run only if both of its halves match the last level
   always_comb begin
      run_d = (bit_clock_oe && bit_clock_o == last_q && mid_q == last_q) ?
         run_q + 6'h01 : 6'h00;
   end

   // first half level of each cycle, taken at the falling edge
   always_ff @(negedge clk) begin
      mid_q <= bit_clock_o;
   end

   always_ff @(posedge clk) begin
      run_q <= rst_b ? run_d : 6'h00;
      last_q <= bit_clock_o;
   end

   ////////////////////////////////////////////////////////////////////////////
   a_div_readback: assert property (@(posedge clk) disable iff (!rst_b)
      rd && addr == ADDR_DIVIDERS && $past(wr, 2) && $past(addr, 2) == ADDR_DIVIDERS
      |=> rdata == $past(wdata, 3)) else $error("divider select readback wrong");
   a_rate_readback: assert property (@(posedge clk) disable iff (!rst_b)
      rd && addr == ADDR_FRAME_CTRL && $past(wr, 2) && $past(addr, 2) == ADDR_FRAME_CTRL
      |=> rdata == $past(wdata, 3)) else $error("frame control readback wrong");
   a_bit_pin_gate: assert property (@(posedge clk) disable iff (!rst_b)
      !bit_clock_oe |-> !bit_clock_o) else $error("bit clock driven while input");
   a_frame_pin_gate: assert property (@(posedge clk) disable iff (!rst_b)
      !frame_clock_oe |-> !frame_clock_o) else $error("frame clock driven while input");
   a_frame_dir_write: assert property (@(posedge clk) disable iff (!rst_b)
      wr && addr == ADDR_FRAME_CTRL |=> frame_clock_oe == $past(wdata[FRAME_DIR_BIT]))
      else $error("frame direction not taken");
   a_bit_dir_write: assert property (@(posedge clk) disable iff (!rst_b)
      wr && addr == ADDR_LINK_CTRL |=> bit_clock_oe == $past(wdata[BCLK_DIR_BIT]))
      else $error("bit clock direction not taken");
   a_dir_hold: assert property (@(posedge clk) disable iff (!rst_b)
      !wr |=> $stable(bit_clock_oe) && $stable(frame_clock_oe))
      else $error("pin direction changed without a write");
   a_no_long_level: assert property (@(posedge clk) disable iff (!rst_b)
      run_q <= 6'h18) else $error("bit clock level held too long");
endmodule // aif_clk_sva

bind audio_if_clock_generator aif_clk_sva aif_clk_sva_i (.clk, .rst_b, .addr, .wdata,
   .wr, .rd, .rdata, .bit_clock_o, .bit_clock_oe, .frame_clock_o, .frame_clock_oe);

// file: verif/tb_audio_if_clock_generator.sv
/*
 * Self-checking bench for the audio interface clock generator.
 * Assumes the host model resolves both clock pins.
 */
`timescale 1ns/1ps
module tb_audio_if_clock_generator import aif_clk_pkg::*;;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rd_d = 1'b0;
   logic [15:0] rdata;
   logic bit_clock_i, bit_clock_o, bit_clock_oe;
   logic frame_clock_i, frame_clock_o, frame_clock_oe, gpio_output_clock;
   int bad_count = 0;
   int cmp_count = 0;
   int seed = 99;
   logic [15:0] exp_q[$];
   // ratios in half system clock periods
   int bh[21] = '{2, 3, 4, 6, 8, 10, 11, 12, 16, 20, 22, 24, 32, 40, 44, 48, 50, 60, 64, 88, 96};
   int gh[9] = '{2, 4, 6, 8, 11, 12, 16, 24, 32};

   audio_if_clock_generator audio_if_clock_generator_i (.clk, .rst_b, .addr, .wdata, .wr,
      .rd, .rdata, .bit_clock_i, .bit_clock_o, .bit_clock_oe, .frame_clock_i,
      .frame_clock_o, .frame_clock_oe, .gpio_output_clock);
   aif_host_model aif_host_model_i (.clk, .rst_b, .bit_o(bit_clock_o), .bit_oe(bit_clock_oe),
      .frame_o(frame_clock_o), .frame_oe(frame_clock_oe), .bit_pin(bit_clock_i),
      .frame_pin(frame_clock_i));

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      exp_q.push_back(e);
      @(posedge clk);
      rd <= 1'b0;
   endtask

   task automatic rise(input int w);
      if (w == 0) @(posedge bit_clock_o);
      else if (w == 1) @(posedge gpio_output_clock);
      else @(posedge frame_clock_o);
   endtask

   // time of n periods in ns
   task automatic per(input int w, input int n, input logic [15:0] e);
      realtime t0;
      rise(w);
      t0 = $realtime;
      repeat (n) rise(w);
      chk(w == 0 ? "bit period" : w == 1 ? "gpio period" : "frame period",
         16'(int'($realtime - t0)), e);
   endtask

   // read data stands only in the cycle after the strobe
   always @(posedge clk) begin
      if (rd_d) chk("rdata", rdata, exp_q.pop_front());
      rd_d <= rd;
   end

   initial begin
      forever #2 clk = ~clk;
   end

   initial begin
      #200000;
      bad_count++;
      finish_test();
   end

   initial begin
      logic [10:0] rate;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      rd_reg(ADDR_DIVIDERS, 16'h0004);
      rd_reg(ADDR_FRAME_CTRL, 16'h0040);
      wr_reg(ADDR_LINK_CTRL, 16'h0040);
      wr_reg(ADDR_FRAME_CTRL, 16'h0840);
      per(0, 2, 16'h0020);
      per(2, 1, 16'h0400);
      for (int i = 0; i < 21; i++) begin
         wr_reg(ADDR_DIVIDERS, {4'h0, 4'(i % 9), 3'h0, 5'(i)});
         rd_reg(ADDR_DIVIDERS, {4'h0, 4'(i % 9), 3'h0, 5'(i)});
         repeat (60) @(posedge clk);
         per(0, 2, 16'(4 * bh[i]));
         per(1, 2, 16'(4 * gh[i % 9]));
      end
      wr_reg(ADDR_DIVIDERS, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         rate = (i == 0) ? 11'h008 : (i == 1) ? 11'h7ff : 11'h008 + 11'($random(seed) & 32'h3ff);
         wr_reg(ADDR_FRAME_CTRL, {5'h01, rate});
         rd_reg(ADDR_FRAME_CTRL, {5'h01, rate});
         repeat (2100) @(posedge clk);
         per(2, 1, 16'(4 * rate));
      end
      wr_reg(8'h00, 16'($random(seed)));
      rd_reg(8'h00, 16'h0000);
      wr_reg(ADDR_FRAME_CTRL, 16'h0040);
      wr_reg(ADDR_LINK_CTRL, 16'h0000);
      repeat (4) @(posedge clk);
      chk("pin drive", {14'h0, bit_clock_oe, frame_clock_oe}, 16'h0000);
      wr_reg(ADDR_DIVIDERS, 16'h0105);
      rst_b <= 1'b0;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      rd_reg(ADDR_DIVIDERS, 16'h0004);
      repeat (4) @(posedge clk);
      finish_test();
   end
endmodule // tb_audio_if_clock_generator
